/* File: core/gpiw_top.sv */
/*
 * Pin interrupt and wake unit of one 32-bit general-purpose port with
 * its Wishbone register file, pad output control and wake status.
 * Assumes one 100 MHz clock, a synchronous active-low reset that merges
 * every reset source, and pad inputs that are asynchronous.
 */
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module gpiw_top
    import gpiw_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [GPIW_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pads
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    // Peripheral alternate functions
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    output logic [31:0] periph_in,
    output logic [31:0] periph_pin_function,
    output logic [31:0] af_select_bit1,
    output logic [31:0] af_select_bit2,
    // Interrupt and wake lines
    output logic port_irq_line,
    output logic pin_wake_irq_line,
    output logic pm_wake_request
);

    // ==========================================================
    // Register state

    // Every instance keeps its own copy of all of this state
    logic [31:0] fsel0, fsel1, fsel2, outen, outlvl;
    logic [31:0] trig_type, trig_pol, inen, irqen, pend, pwken, both;
    logic [31:0] pada, padb, hys, slew, dslo, dshi, pull, vsel;
    logic [31:0] aon_wstat, aon_wen;
    logic pm_wen;
    logic [31:0] next_fsel0, next_fsel1, next_fsel2, next_outen;
    logic [31:0] next_outlvl, next_trig_type, next_trig_pol, next_inen;
    logic [31:0] next_irqen, next_pend, next_pwken, next_both;
    logic [31:0] next_pada, next_padb, next_hys, next_slew, next_dslo;
    logic [31:0] next_dshi, next_pull, next_vsel, next_aon_wstat;
    logic [31:0] next_aon_wen;
    logic next_pm_wen;

    // Bus state
    logic ack, next_ack;
    logic [31:0] rdat, next_rdat;
    logic wr, rd;
    logic [31:0] wmask, wdat;

    // Pin sampling state
    logic [31:0] sync1, sync2, sync3, lvl, lvl_prev;
    logic [31:0] next_lvl;

    // Detection terms
    logic [31:0] rise, fall, io_mode, edge_hit, level_hit, pin_event;
    logic [31:0] wake_edge;
    logic next_irq, next_wake, next_pmreq;

    // ==========================================================
    // Bus decode

    // Request is taken on the first cycle of a strobe; ack follows
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i & wmask;

    // Byte-lane merge for plain read-write registers
    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (cur & ~m) | (d & m);
    endfunction : merge

    // Ones written to set or clear offsets act bit by bit
    function automatic logic [31:0] apply(input logic [31:0] cur,
                                          input logic [7:0] adr,
                                          input logic [7:0] base,
                                          input logic [7:0] set_ofs,
                                          input logic [7:0] clr_ofs,
                                          input logic [31:0] d,
                                          input logic [31:0] m);
        apply = cur;
        if (adr == base) begin
            apply = merge(cur, d, m);
        end else if (adr == set_ofs) begin
            apply = cur | d;
        end else if (adr == clr_ofs) begin
            apply = cur & ~d;
        end
    endfunction : apply

    // ==========================================================
    // Pin sampling and edge detection

    // Three flops; a level change is taken once stages two and three agree
    always_comb begin
        next_lvl = lvl;
        for (int i = 0; i < GPIW_W; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_lvl[i] = sync3[i];
            end
        end
    end

    // Edges come from the filtered level against its previous sample
    assign rise = lvl & ~lvl_prev;
    assign fall = ~lvl & lvl_prev;

    // ==========================================================
    // Interrupt detection

    // Function bit zero set means software I/O, clear means alternate
    assign io_mode = fsel0;
    // Edge choice: both-edges overrides the polarity bit
    assign edge_hit = (both & (rise | fall))
                    | (~both & ~trig_pol & rise)
                    | (~both & trig_pol & fall);
    // Level choice: polarity one means high is active
    assign level_hit = (trig_pol & lvl) | (~trig_pol & ~lvl);
    // Alternate-function pins are gated off here; the peripheral owns them
    assign pin_event = io_mode & inen
                     & ((trig_type & edge_hit)
                     | (~trig_type & level_hit));

    // Wake sees edges only, since levels need the clock running
    assign wake_edge = (rise | fall)
                     & aon_wen & pwken
                     & {32{pm_wen}};

    // ==========================================================
    // Register next values

    // Set by hardware wins over a clear written in the same cycle
    always_comb begin
        next_fsel0 = fsel0;
        next_fsel1 = fsel1;
        next_fsel2 = fsel2;
        next_outen = outen;
        next_outlvl = outlvl;
        next_trig_type = trig_type;
        next_trig_pol = trig_pol;
        next_inen = inen;
        next_irqen = irqen;
        next_pwken = pwken;
        next_both = both;
        next_pada = pada;
        next_padb = padb;
        next_hys = hys;
        next_slew = slew;
        next_dslo = dslo;
        next_dshi = dshi;
        next_pull = pull;
        next_vsel = vsel;
        next_aon_wen = aon_wen;
        next_pm_wen = pm_wen;
        next_pend = pend;
        next_aon_wstat = aon_wstat;
        if (wr) begin
            next_fsel0 = apply(fsel0, wb_adr_i, OFS_FSEL0, OFS_FSEL0_SET,
                               OFS_FSEL0_CLR, wdat, wmask);
            next_fsel1 = apply(fsel1, wb_adr_i, OFS_FSEL1, OFS_FSEL1_SET,
                               OFS_FSEL1_CLR, wdat, wmask);
            next_fsel2 = apply(fsel2, wb_adr_i, OFS_FSEL2, OFS_FSEL2_SET,
                               OFS_FSEL2_CLR, wdat, wmask);
            next_outen = apply(outen, wb_adr_i, OFS_OUTEN, OFS_OUTEN_SET,
                               OFS_OUTEN_CLR, wdat, wmask);
            next_outlvl = apply(outlvl, wb_adr_i, OFS_OUTLVL,
                                OFS_OUTLVL_SET, OFS_OUTLVL_CLR, wdat,
                                wmask);
            // Per-pin enables, any subset
            next_irqen = apply(irqen, wb_adr_i, OFS_IRQEN, OFS_IRQEN_SET,
                               OFS_IRQEN_CLR, wdat, wmask);
            next_pwken = apply(pwken, wb_adr_i, OFS_PWKEN, OFS_PWKEN_SET,
                               OFS_PWKEN_CLR, wdat, wmask);
            case (wb_adr_i)
                OFS_TRIG_TYPE: next_trig_type = merge(trig_type, wdat, wmask);
                OFS_TRIG_POL: next_trig_pol = merge(trig_pol, wdat, wmask);
                OFS_INEN: next_inen = merge(inen, wdat, wmask);
                OFS_BOTH: next_both = merge(both, wdat, wmask);
                OFS_PADA: next_pada = merge(pada, wdat, wmask);
                OFS_PADB: next_padb = merge(padb, wdat, wmask);
                OFS_HYS: next_hys = merge(hys, wdat, wmask);
                OFS_SLEW: next_slew = merge(slew, wdat, wmask);
                OFS_DSLO: next_dslo = merge(dslo, wdat, wmask);
                OFS_DSHI: next_dshi = merge(dshi, wdat, wmask);
                OFS_PULL: next_pull = merge(pull, wdat, wmask);
                OFS_VSEL: next_vsel = merge(vsel, wdat, wmask);
                OFS_AON_WEN: next_aon_wen = merge(aon_wen, wdat, wmask);
                OFS_PM_WEN: begin
                    if (wb_sel_i[0]) begin
                        next_pm_wen = wb_dat_i[0];
                    end
                end
                OFS_PEND_CLR: next_pend = pend & ~wdat;
                OFS_AON_WSTAT: next_aon_wstat = aon_wstat & ~wdat;
                default: begin
                end
            endcase
        end
        // Detected events latch after any clear in this cycle
        next_pend = next_pend | pin_event;
        next_aon_wstat = next_aon_wstat | wake_edge;
    end

    // Reading the flags has no side effect; pend clears by its clear offset, wake status by ones written to its own offset
    always_comb begin
        next_ack = wb_cyc_i & wb_stb_i & ~ack;
        next_rdat = rdat;
        if (rd) begin
            case (wb_adr_i)
                OFS_FSEL0: next_rdat = fsel0;
                OFS_FSEL1: next_rdat = fsel1;
                OFS_FSEL2: next_rdat = fsel2;
                OFS_OUTEN: next_rdat = outen;
                OFS_OUTLVL: next_rdat = outlvl;
                OFS_INLVL: next_rdat = lvl & inen;
                OFS_TRIG_TYPE: next_rdat = trig_type;
                OFS_TRIG_POL: next_rdat = trig_pol;
                OFS_INEN: next_rdat = inen;
                OFS_IRQEN: next_rdat = irqen;
                OFS_PEND: next_rdat = pend;
                OFS_PWKEN: next_rdat = pwken;
                OFS_BOTH: next_rdat = both;
                OFS_PADA: next_rdat = pada;
                OFS_PADB: next_rdat = padb;
                OFS_HYS: next_rdat = hys;
                OFS_SLEW: next_rdat = slew;
                OFS_DSLO: next_rdat = dslo;
                OFS_DSHI: next_rdat = dshi;
                OFS_PULL: next_rdat = pull;
                OFS_VSEL: next_rdat = vsel;
                OFS_AON_WSTAT: next_rdat = aon_wstat;
                OFS_AON_WEN: next_rdat = aon_wen;
                OFS_PM_WEN: next_rdat = {31'h0000_0000, pm_wen};
                default: next_rdat = RST_ZERO;
            endcase
        end
    end

    // Port line stays valid in light sleep since the clock still runs
    always_comb begin
        next_irq = |(pend & irqen);
        next_wake = |aon_wstat;
        next_pmreq = |wake_edge;
    end

    // ==========================================================
    // Registers

    // One merged reset covers system, soft, power-on and port resets
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fsel0 <= RST_FSEL0;
            fsel1 <= RST_ZERO;
            fsel2 <= RST_ZERO;
            outen <= RST_ZERO;
            outlvl <= RST_ZERO;
            trig_type <= RST_ZERO;
            trig_pol <= RST_ZERO;
            inen <= RST_INEN;
            irqen <= RST_ZERO;
            pend <= RST_ZERO;
            pwken <= RST_ZERO;
            both <= RST_ZERO;
            pada <= RST_ZERO;
            padb <= RST_ZERO;
            hys <= RST_ZERO;
            slew <= RST_ZERO;
            dslo <= RST_ZERO;
            dshi <= RST_ZERO;
            pull <= RST_ZERO;
            vsel <= RST_ZERO;
            aon_wstat <= RST_ZERO;
            aon_wen <= RST_ZERO;
            pm_wen <= 1'b0;
            ack <= 1'b0;
            rdat <= RST_ZERO;
            port_irq_line <= 1'b0;
            pin_wake_irq_line <= 1'b0;
            pm_wake_request <= 1'b0;
        end else begin
            fsel0 <= next_fsel0;
            fsel1 <= next_fsel1;
            fsel2 <= next_fsel2;
            outen <= next_outen;
            outlvl <= next_outlvl;
            trig_type <= next_trig_type;
            trig_pol <= next_trig_pol;
            inen <= next_inen;
            irqen <= next_irqen;
            pend <= next_pend;
            pwken <= next_pwken;
            both <= next_both;
            pada <= next_pada;
            padb <= next_padb;
            hys <= next_hys;
            slew <= next_slew;
            dslo <= next_dslo;
            dshi <= next_dshi;
            pull <= next_pull;
            vsel <= next_vsel;
            aon_wstat <= next_aon_wstat;
            aon_wen <= next_aon_wen;
            pm_wen <= next_pm_wen;
            ack <= next_ack;
            rdat <= next_rdat;
            port_irq_line <= next_irq;
            pin_wake_irq_line <= next_wake;
            pm_wake_request <= next_pmreq;
        end
    end

    // Synchroniser and sample history; the chain keeps loading during
    // reset so the history equals the pin on release and no false edge
    // follows reset (a reset of four cycles or more flushes it)
    always_ff @(posedge clock) begin
        sync1 <= pad_in;
        sync2 <= sync1;
        sync3 <= sync2;
        if (!rst_n) begin
            lvl <= sync3;
            lvl_prev <= sync3;
        end else begin
            lvl <= next_lvl;
            lvl_prev <= lvl;
        end
    end

    // ==========================================================
    // Outputs

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    // Output level is ignored unless the pin is in I/O mode; outen drives only pad_oe
    assign pad_out = (io_mode & outlvl) | (~io_mode & periph_out);
    assign pad_oe = (io_mode & outen) | (~io_mode & periph_oe);
    assign periph_in = lvl;
    assign periph_pin_function = ~io_mode;
    assign af_select_bit1 = fsel1;
    assign af_select_bit2 = fsel2;

endmodule : gpiw_top

/* File: core/gpiw_pkg.sv */
/*
 * Package of the pin interrupt and wake unit: register offsets, reset
 * values and widths shared by the design and the bench.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
package gpiw_pkg;

    // ==========================================================
    // Widths
    localparam int GPIW_W = 32;
    localparam int GPIW_AW = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_FSEL0 = 8'h00;
    localparam logic [7:0] OFS_FSEL0_SET = 8'h04;
    localparam logic [7:0] OFS_FSEL0_CLR = 8'h08;
    localparam logic [7:0] OFS_OUTEN = 8'h0c;
    localparam logic [7:0] OFS_OUTEN_SET = 8'h10;
    localparam logic [7:0] OFS_OUTEN_CLR = 8'h14;
    localparam logic [7:0] OFS_OUTLVL = 8'h18;
    localparam logic [7:0] OFS_OUTLVL_SET = 8'h1c;
    localparam logic [7:0] OFS_OUTLVL_CLR = 8'h20;
    localparam logic [7:0] OFS_INLVL = 8'h24;
    localparam logic [7:0] OFS_TRIG_TYPE = 8'h28;
    localparam logic [7:0] OFS_TRIG_POL = 8'h2c;
    localparam logic [7:0] OFS_INEN = 8'h30;
    localparam logic [7:0] OFS_IRQEN = 8'h34;
    localparam logic [7:0] OFS_IRQEN_SET = 8'h38;
    localparam logic [7:0] OFS_IRQEN_CLR = 8'h3c;
    localparam logic [7:0] OFS_PEND = 8'h40;
    localparam logic [7:0] OFS_PEND_CLR = 8'h48;
    localparam logic [7:0] OFS_PWKEN = 8'h4c;
    localparam logic [7:0] OFS_PWKEN_SET = 8'h50;
    localparam logic [7:0] OFS_PWKEN_CLR = 8'h54;
    localparam logic [7:0] OFS_BOTH = 8'h5c;
    localparam logic [7:0] OFS_PADA = 8'h60;
    localparam logic [7:0] OFS_PADB = 8'h64;
    localparam logic [7:0] OFS_FSEL1 = 8'h68;
    localparam logic [7:0] OFS_FSEL1_SET = 8'h6c;
    localparam logic [7:0] OFS_FSEL1_CLR = 8'h70;
    localparam logic [7:0] OFS_FSEL2 = 8'h74;
    localparam logic [7:0] OFS_FSEL2_SET = 8'h78;
    localparam logic [7:0] OFS_FSEL2_CLR = 8'h7c;
    localparam logic [7:0] OFS_HYS = 8'ha8;
    localparam logic [7:0] OFS_SLEW = 8'hac;
    localparam logic [7:0] OFS_DSLO = 8'hb0;
    localparam logic [7:0] OFS_DSHI = 8'hb4;
    localparam logic [7:0] OFS_PULL = 8'hb8;
    localparam logic [7:0] OFS_VSEL = 8'hc0;
    localparam logic [7:0] OFS_AON_WSTAT = 8'hd0;
    localparam logic [7:0] OFS_AON_WEN = 8'hd4;
    localparam logic [7:0] OFS_PM_WEN = 8'hd8;

    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_FSEL0 = 32'hffff_ffff;
    localparam logic [31:0] RST_INEN = 32'h0000_0303;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage : gpiw_pkg

/* File: dv/gpiw_pad_model.sv */
/* Far-side model: outside pad levels and a peripheral that owns pins
   in alternate mode. Assumes the bench sets the outside levels. */
`timescale 1ns/1ps
module gpiw_pad_model (
    // Clock
    input wire logic clock,
    // Outside levels and the unit's pad drive
    input wire logic [31:0] ext_lvl,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    // Wire levels and peripheral drive
    output logic [31:0] pad_in,
    output logic [31:0] periph_out,
    output logic [31:0] periph_oe
);
    // ==========================================================
    // Wire and peripheral
    logic [31:0] pat = 32'h0000_0001;
    // Driven pins show the unit's value, the rest the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
    // Pattern moves every cycle, so a stale output mux shows up
    always_ff @(posedge clock) begin
        pat <= pat + 32'h0001_0003;
    end
    assign periph_out = pat;
    assign periph_oe = ~pat;
endmodule : gpiw_pad_model

/* File: dv/gpiw_monitor.sv */
/* Checker of the unit's ports: bus answer timing, output mux and the
   causes of the interrupt and wake lines. Bound into gpiw_top. */
`timescale 1ns/1ps
module gpiw_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pads and peripheral
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    input wire logic [31:0] periph_pin_function,
    // Lines
    input wire logic port_irq_line,
    input wire logic pin_wake_irq_line,
    input wire logic pm_wake_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Steps of a bus access
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_timing: assert property (s_take |=> s_answer)
        else $error("ack not one cycle after request");
    chk_ack_cause: assert property (wb_ack_o |->
        $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without request");
    // Read data may only move after a read was taken
    chk_dat_hold: assert property (!$stable(wb_dat_o) |->
        $past(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o))
        else $error("read data moved without read");
    // ==========================================================
    // Peripheral-owned pins follow the peripheral drive
    chk_mux_oe: assert property ((pad_oe & periph_pin_function) ==
        (periph_oe & periph_pin_function))
        else $error("pad enable not from peripheral");
    chk_mux_out: assert property ((pad_out & periph_pin_function) ==
        (periph_out & periph_pin_function))
        else $error("pad value not from peripheral");
    // ==========================================================
    // Lines drop only after software writes, wake follows a request
    chk_irq_clear: assert property ($fell(port_irq_line) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("port line fell without write");
    chk_wake_line: assert property (pm_wake_request |->
        ##[1:2] pin_wake_irq_line)
        else $error("wake line missing after wake");
    chk_wake_cause: assert property ($rose(pin_wake_irq_line) |->
        $past(pm_wake_request) || $past(pm_wake_request, 2))
        else $error("wake line rose without wake");
    chk_wake_clear: assert property ($fell(pin_wake_irq_line) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("wake line fell without write");
endmodule : gpiw_monitor
bind gpiw_top gpiw_monitor i_mon (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_out(pad_out),
    .pad_oe(pad_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_pin_function(periph_pin_function),
    .port_irq_line(port_irq_line), .pin_wake_irq_line(pin_wake_irq_line),
    .pm_wake_request(pm_wake_request));

/* File: dv/gpiw_tb_top.sv */
/* Bench of the pin interrupt and wake unit: reset image, atomic access,
   trigger sweep, masking, alternate mode and wake. Assumes gpiw_pkg,
   the pad model and the bound checker. */
`timescale 1ns/1ps
module gpiw_tb_top;
    import gpiw_pkg::*;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] lvl = 32'hffff_ffff;
    logic [31:0] rv, wb_dat_o, pad_in, pad_out, pad_oe, p_out, p_oe, ppf;
    logic wb_ack_o, port_irq_line, pin_wake_irq_line, pm_wake_request;
    logic [31:0] p_in, fs1, fs2;
    int err_total = 0;
    int n_checks = 0;
    int seed = 2312;
    // Reset image, unmapped offset last
    localparam logic [7:0] RA [6] = '{OFS_FSEL0, OFS_INEN, OFS_IRQEN,
        OFS_TRIG_POL, OFS_AON_WSTAT, 8'hfc};
    localparam logic [31:0] RV [6] = '{RST_FSEL0, RST_INEN, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO};
    always #5 clock = ~clock;
    gpiw_top i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
        .periph_pin_function(ppf), .af_select_bit1(fs1),
        .af_select_bit2(fs2),
        .port_irq_line(port_irq_line), .pin_wake_irq_line(pin_wake_irq_line),
        .pm_wake_request(pm_wake_request));
    gpiw_pad_model i_pads (.clock(clock), .ext_lvl(lvl), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_in(pad_in), .periph_out(p_out),
        .periph_oe(p_oe));
    // ==========================================================
    // Bus and compare tasks; the request holds until ack is seen, and
    // only the watchdog ends a wait that never gets an answer
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rv = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rv, exp);
    endtask : rchk
    // Toggle one outside pin, then let it pass the synchroniser
    task automatic flip(input int p);
        lvl[p] <= ~lvl[p];
        repeat (10) @(posedge clock);
    endtask : flip
    // Flag is sticky: a level counts if seen before or after the step
    function automatic logic exp_pend(input logic t, pl, bo, v0, v1);
        if (!t)
            return (v0 == pl) || (v1 == pl);
        return (v0 != v1) && (bo || (v1 == !pl));
    endfunction : exp_pend
    // ==========================================================
    // One trigger kind on pin p, configured in the safe order
    task automatic trial(input logic [4:0] p, input logic [4:0] k);
        logic t, pl, bo, v0, v1, e;
        logic [31:0] m;
        {t, pl, bo, v0, v1} = k;
        m = 32'h0000_0001 << p;
        e = exp_pend(t, pl, bo, v0, v1);
        wr(OFS_INEN, 32'h0000_0000);
        lvl[p] <= v0;
        wr(OFS_PEND_CLR, 32'hffff_ffff);
        wr(OFS_TRIG_TYPE, {32{t}} & m);
        wr(OFS_TRIG_POL, {32{pl}} & m);
        wr(OFS_BOTH, {32{bo}} & m);
        wr(OFS_INEN, m);
        wr(OFS_IRQEN, m);
        repeat (8) @(posedge clock);
        wr(OFS_PEND_CLR, m);
        lvl[p] <= v1;
        repeat (10) @(posedge clock);
        rchk(OFS_PEND, {32{e}} & m);
        chk({31'h0, port_irq_line}, {31'h0, e});
        wr(OFS_PEND_CLR, rv);
        repeat (3) @(posedge clock);
        rchk(OFS_PEND, {32{!t && v1 == pl}} & m);
    endtask : trial
    // Verdict, reached from the main sequence or the watchdog
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r, c, m;
        int q;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        foreach (RA[i])
            rchk(RA[i], RV[i]);
        r = $random(seed);
        c = $random(seed);
        wr(OFS_IRQEN_SET, r);
        wr(OFS_IRQEN_CLR, c);
        rchk(OFS_IRQEN, r & ~c);
        rchk(OFS_IRQEN_SET, 32'h0000_0000);
        wr(OFS_FSEL1, r);
        wr(OFS_FSEL2_SET, c);
        chk(fs1, r);
        chk(fs2, c);
        for (int k = 0; k < 32; k++) begin
            q = $random(seed);
            trial(q[4:0], k[4:0]);
        end
        q = $random(seed);
        m = 32'h0000_0001 << q[4:0];
        wr(OFS_IRQEN, 32'h0000_0000);
        wr(OFS_INEN, m);
        wr(OFS_BOTH, m);
        wr(OFS_TRIG_TYPE, m);
        wr(OFS_PEND_CLR, 32'hffff_ffff);
        flip(q[4:0]);
        rchk(OFS_PEND, m);
        chk({31'h0, port_irq_line}, 32'h0000_0000);
        wr(OFS_IRQEN_SET, m);
        repeat (2) @(posedge clock);
        chk({31'h0, port_irq_line}, 32'h0000_0001);
        wr(OFS_INEN, 32'h0000_0000);
        flip(q[4:0]);
        rchk(OFS_PEND, m);
        wr(OFS_PEND_CLR, m);
        flip(q[4:0]);
        rchk(OFS_PEND, 32'h0000_0000);
        wr(OFS_INEN, m);
        wr(OFS_FSEL0_CLR, m);
        chk(ppf, m);
        flip(q[4:0]);
        rchk(OFS_PEND, 32'h0000_0000);
        wr(OFS_FSEL0_SET, m);
        rchk(OFS_FSEL0, RST_FSEL0);
        wr(OFS_AON_WSTAT, 32'hffff_ffff);
        wr(OFS_AON_WEN, m);
        wr(OFS_PWKEN, m);
        wr(OFS_PM_WEN, 32'h0000_0001);
        flip(q[4:0]);
        rchk(OFS_AON_WSTAT, m);
        chk({31'h0, pin_wake_irq_line}, 32'h0000_0001);
        wr(OFS_TRIG_TYPE, 32'h0000_0000);
        wr(OFS_TRIG_POL, lvl);
        wr(OFS_AON_WSTAT, m);
        repeat (10) @(posedge clock);
        rchk(OFS_AON_WSTAT, 32'h0000_0000);
        wr(OFS_PM_WEN, 32'h0000_0000);
        flip(q[4:0]);
        rchk(OFS_AON_WSTAT, 32'h0000_0000);
        wr(OFS_PM_WEN, 32'h0000_0001);
        wr(OFS_AON_WEN, 32'h0000_0000);
        flip(q[4:0]);
        rchk(OFS_AON_WSTAT, 32'h0000_0000);
        // Drive the pin from the unit and see it come back on the input
        wr(OFS_OUTLVL_SET, m);
        wr(OFS_OUTEN_SET, m);
        repeat (5) @(posedge clock);
        chk(pad_oe & pad_out & p_in & m, m);
        // Second reset in mid-run, pads parked high first
        lvl <= 32'hffff_ffff;
        repeat (10) @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        foreach (RA[i])
            rchk(RA[i], RV[i]);
        summarize();
    end
endmodule : gpiw_tb_top
